// ===== rtl/mbpm_cfg.svh
// Offsets, field positions, reset values for the match based pulse modulator
// Included by the top design module
`ifndef MBPM_CFG_SVH
`define MBPM_CFG_SVH

// Register byte offsets
`define MBPM_OFF_CTRL     8'h00
`define MBPM_OFF_FLAGS    8'h04
`define MBPM_OFF_COUNT    8'h08
`define MBPM_OFF_PRESCALE 8'h0c
`define MBPM_OFF_PRECOUNT 8'h10
`define MBPM_OFF_MATCHCTL 8'h14
`define MBPM_OFF_CNTCTL   8'h18
`define MBPM_OFF_CAPCTL   8'h1c
`define MBPM_OFF_CAP0     8'h20
`define MBPM_OFF_CAP1     8'h24
`define MBPM_OFF_PULSECTL 8'h28
`define MBPM_OFF_RELEASE  8'h2c
`define MBPM_OFF_MATCH0   8'h40
`define MBPM_OFF_MATCH6   8'h58

// Control register fields
`define MBPM_CTRL_EN      0
`define MBPM_CTRL_RST     1
`define MBPM_CTRL_PULSE   2

// Flag register: capture flags sit above match flags
`define MBPM_FLAG_CAP     8

// Match control: three bits per match register
`define MBPM_MC_INT       0
`define MBPM_MC_RST       1
`define MBPM_MC_STOP      2
`define MBPM_MC_W         3

// Counter control: mode in [1:0], capture select at bit 2
`define MBPM_CC_SEL       2

// Capture control: three bits per capture input
`define MBPM_CAP_RISE     0
`define MBPM_CAP_FALL     1
`define MBPM_CAP_INT      2

// Pulse control: double edge select at n, output enable at 8+n
`define MBPM_PC_OEN       8

`define MBPM_RESET_WORD   32'h0000_0000

`endif

// ===== rtl/mbpm_match.sv
// One match channel: shadow value and equality compare
// Assumes the top decides when a released value may be applied
`timescale 1ns/1ps
module mbpm_match import mbpm_pkg::*; #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Values
  input  wire logic [W-1:0] sw_value,
  input  wire logic         apply,
  input  wire logic [W-1:0] count,
  // Compare
  output logic              hit
);
  logic [W-1:0] shadow_q;
  logic [W-1:0] shadow_d;

  always_comb begin
    shadow_d = apply ? sw_value : shadow_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= '0;
    end else begin
      shadow_q <= shadow_d;
    end
  end

  assign hit = (count == shadow_q);
endmodule

// ===== rtl/mbpm_pkg.sv
// Types shared by the match based pulse modulator design files
// Holds no numeric constants; those stay in mbpm_cfg.svh
package mbpm_pkg;
  typedef enum logic [1:0] {
    MBPM_TIMER,
    MBPM_RISE,
    MBPM_FALL,
    MBPM_BOTH
  } mbpm_cnt_mode_t;
endpackage

// ===== rtl/mbpm_top.sv
// Match based pulse modulator: timer, prescaler, seven matches, six outputs
// Assumes an APB master on pclk; capture inputs synchronous to pclk
//
// Summary of operation
// R1: 32-bit counter advanced through a programmable 32-bit prescaler.
// R2: Count peripheral clock ticks or edges of a selected capture input.
// R3: Seven match registers serve up to six single or three double edge outputs.
// R4: Match zero sets the period and restarts the counter.
// R5: Single edge outputs rise at each cycle start unless held low.
// R6: Each single edge output uses one match register for its falling edge.
// R7: Each double edge output uses two match registers.
// R8: One match sets, the other clears; order gives positive or negative pulse.
// R9: Either double edge may sit at any count in the cycle.
// R10: Period and width are any count; all outputs share one rate.
// R11: Each match may continue, stop or reset, optionally flagging an interrupt.
// R12: New match values apply only after release, at the cycle start.
// R13: Without pulse mode the block is a plain timer.
// R14: Software syncs two units by equal setup and a simultaneous enable.
// R15: Capture edges latch the counter, optionally flagging an interrupt.
// R16: A match is counter equal to match value, checked once per increment.
// R17: After reset counter, prescaler and outputs are cleared and stopped.
`timescale 1ns/1ps
`include "mbpm_cfg.svh"
module mbpm_top import mbpm_pkg::*; #(
  parameter int NMATCH = 7, // see R3
  parameter int NOUT   = 6,
  parameter int NCAP   = 2
) (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Capture inputs
  input  wire logic [NCAP-1:0] cap_in,
  // Pulse outputs, bit n is output n
  output logic [NOUT:1]        pulse_out,
  // Interrupt request level
  output logic                 irq
);
  // Software registers
  logic [2:0]              ctrl_q, ctrl_d;
  logic [31:0]             prescale_q, prescale_d;
  logic [NMATCH*3-1:0]     match_ctl_q, match_ctl_d;
  logic [2:0]              cnt_ctl_q, cnt_ctl_d;
  logic [NCAP*3-1:0]       cap_ctl_q, cap_ctl_d;
  logic [15:0]             pulse_ctl_q, pulse_ctl_d;
  logic [NMATCH-1:0]       release_q, release_d;
  logic [31:0]             match_q [NMATCH];
  logic [31:0]             match_d [NMATCH];
  // Timer state
  logic [31:0]             count_q, count_d;
  logic [31:0]             precount_q, precount_d;
  logic [31:0]             cap_q [NCAP];
  logic [31:0]             cap_d [NCAP];
  logic [NMATCH+7:0]       flags_q, flags_d;
  logic [NCAP-1:0]         cap_prev_q;
  logic [NOUT:1]           pulse_d;
  logic                    irq_d;
  // Bus
  logic [31:0]             rdata_d;
  logic                    ready_d;
  logic                    err_d;
  // Internal
  logic                    access;
  logic                    wr;
  logic                    mapped;
  logic [NCAP-1:0]         rise;
  logic [NCAP-1:0]         fall;
  logic                    src_ev;
  logic                    tick;
  logic [NMATCH-1:0]       hit;
  logic [NMATCH-1:0]       match_ev;
  logic                    cycle_start;
  logic                    any_reset;
  logic                    any_stop;
  logic [NMATCH-1:0]       apply;
  logic [NCAP-1:0]         sel_rise;
  logic [NCAP-1:0]         sel_fall;
  logic [$clog2(NCAP)-1:0] sel;
  logic [2:0]              midx;

  assign access = psel && penable && !pready;
  assign wr     = psel && penable && pready && pwrite && !pslverr;
  assign midx   = 3'((paddr - `MBPM_OFF_MATCH0) >> 2);
  assign sel    = cnt_ctl_q[`MBPM_CC_SEL +: $clog2(NCAP)];
  assign rise   = cap_in & ~cap_prev_q;
  assign fall   = ~cap_in & cap_prev_q;
  assign sel_rise = rise & (NCAP'(1) << sel);
  assign sel_fall = fall & (NCAP'(1) << sel);

  // Count source selection
  always_comb begin
    case (mbpm_cnt_mode_t'(cnt_ctl_q[1:0]))
      MBPM_TIMER: src_ev = 1'b1; // see R2
      MBPM_RISE:  src_ev = |sel_rise;
      MBPM_FALL:  src_ev = |sel_fall;
      MBPM_BOTH:  src_ev = |sel_rise || |sel_fall;
      default:    src_ev = 1'b0;
    endcase
  end

  assign tick = ctrl_q[`MBPM_CTRL_EN] && !ctrl_q[`MBPM_CTRL_RST] && src_ev
             && (precount_q == prescale_q); // see R1

  // Match channels
  genvar g;
  generate
    for (g = 0; g < NMATCH; g++) begin : g_match
      mbpm_match #(.W(32)) u_match (
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_value (match_q[g]),
        .apply    (apply[g]),
        .count    (count_q),
        .hit      (hit[g])
      );
    end
  endgenerate

  // Matches evaluated once per increment
  always_comb begin
    match_ev  = hit & {NMATCH{tick}}; // see R16
    any_reset = 1'b0;
    any_stop  = 1'b0;
    for (int i = 0; i < NMATCH; i++) begin
      any_reset = any_reset || (match_ev[i] && match_ctl_q[i*3 + `MBPM_MC_RST]); // see R11
      any_stop  = any_stop  || (match_ev[i] && match_ctl_q[i*3 + `MBPM_MC_STOP]);
    end
    cycle_start = match_ev[0]; // see R4
  end

  // Released values load at cycle start; plain timer loads at once
  always_comb begin
    for (int i = 0; i < NMATCH; i++) begin
      apply[i] = ctrl_q[`MBPM_CTRL_PULSE] ? (release_q[i] && cycle_start)
                                          : 1'b1; // see R12
    end
  end

  // Prescaler and counter
  always_comb begin
    precount_d = precount_q;
    count_d    = count_q;
    if (!ctrl_q[`MBPM_CTRL_EN] || ctrl_q[`MBPM_CTRL_RST]) begin
      precount_d = '0; // see R17
      if (ctrl_q[`MBPM_CTRL_RST]) begin
        count_d = '0;
      end
    end else if (src_ev) begin
      precount_d = (precount_q == prescale_q) ? '0 : precount_q + 32'h1;
    end
    if (tick) begin
      count_d = any_reset ? '0 : count_q + 32'h1; // see R4, R10
    end
  end

  // Captures and flags
  always_comb begin
    flags_d = flags_q;
    if (wr && paddr == `MBPM_OFF_FLAGS) begin
      flags_d = flags_q & ~pwdata[NMATCH+7:0];
    end
    for (int i = 0; i < NMATCH; i++) begin
      if (match_ev[i] && match_ctl_q[i*3 + `MBPM_MC_INT]) begin
        flags_d[i] = 1'b1; // see R11
      end
    end
    for (int c = 0; c < NCAP; c++) begin
      cap_d[c] = cap_q[c];
      if ((rise[c] && cap_ctl_q[c*3 + `MBPM_CAP_RISE])
          || (fall[c] && cap_ctl_q[c*3 + `MBPM_CAP_FALL])) begin
        cap_d[c] = count_q; // see R15
        if (cap_ctl_q[c*3 + `MBPM_CAP_INT]) begin
          flags_d[`MBPM_FLAG_CAP + c] = 1'b1;
        end
      end
    end
    irq_d = |flags_d;
  end

  // Pulse edges
  always_comb begin
    for (int n = 1; n <= NOUT; n++) begin
      logic set_ev;
      logic clr_ev;
      set_ev = match_ev[0]; // see R5, R6
      clr_ev = match_ev[n];
      if (n >= 2 && pulse_ctl_q[n]) begin
        set_ev = match_ev[n-1]; // see R7, R8, R9
      end
      if (!ctrl_q[`MBPM_CTRL_PULSE] || !pulse_ctl_q[`MBPM_PC_OEN + n]) begin
        pulse_d[n] = 1'b0; // see R5, R13
      end else if (clr_ev) begin
        pulse_d[n] = 1'b0;
      end else if (set_ev) begin
        pulse_d[n] = 1'b1;
      end else begin
        pulse_d[n] = pulse_out[n];
      end
    end
  end

  // Software register writes
  always_comb begin
    ctrl_d      = ctrl_q;
    prescale_d  = prescale_q;
    match_ctl_d = match_ctl_q;
    cnt_ctl_d   = cnt_ctl_q;
    cap_ctl_d   = cap_ctl_q;
    pulse_ctl_d = pulse_ctl_q;
    release_d   = release_q;
    for (int i = 0; i < NMATCH; i++) begin
      match_d[i] = match_q[i];
      if (apply[i] && ctrl_q[`MBPM_CTRL_PULSE]) begin
        release_d[i] = 1'b0;
      end
    end
    if (any_stop) begin
      ctrl_d[`MBPM_CTRL_EN] = 1'b0; // see R11
    end
    if (wr) begin
      case (paddr)
        `MBPM_OFF_CTRL:     ctrl_d      = pwdata[2:0];
        `MBPM_OFF_PRESCALE: prescale_d  = pwdata;
        `MBPM_OFF_MATCHCTL: match_ctl_d = pwdata[NMATCH*3-1:0];
        `MBPM_OFF_CNTCTL:   cnt_ctl_d   = pwdata[2:0];
        `MBPM_OFF_CAPCTL:   cap_ctl_d   = pwdata[NCAP*3-1:0];
        `MBPM_OFF_PULSECTL: pulse_ctl_d = pwdata[15:0];
        `MBPM_OFF_RELEASE:  release_d   = release_d | pwdata[NMATCH-1:0];
        default: begin
          if (paddr >= `MBPM_OFF_MATCH0 && paddr <= `MBPM_OFF_MATCH6) begin
            match_d[midx] = pwdata;
          end
        end
      endcase
    end
  end

  // Bus answer: one wait state, then ready with data
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr <= `MBPM_OFF_RELEASE
           || (paddr >= `MBPM_OFF_MATCH0 && paddr <= `MBPM_OFF_MATCH6));
    ready_d = access;
    err_d   = access && !mapped;
    rdata_d = '0;
    if (access && !pwrite && mapped) begin
      case (paddr)
        `MBPM_OFF_CTRL:     rdata_d = {29'h0, ctrl_q};
        `MBPM_OFF_FLAGS:    rdata_d = 32'(flags_q);
        `MBPM_OFF_COUNT:    rdata_d = count_q;
        `MBPM_OFF_PRESCALE: rdata_d = prescale_q;
        `MBPM_OFF_PRECOUNT: rdata_d = precount_q;
        `MBPM_OFF_MATCHCTL: rdata_d = 32'(match_ctl_q);
        `MBPM_OFF_CNTCTL:   rdata_d = {29'h0, cnt_ctl_q};
        `MBPM_OFF_CAPCTL:   rdata_d = 32'(cap_ctl_q);
        `MBPM_OFF_CAP0:     rdata_d = cap_q[0];
        `MBPM_OFF_CAP1:     rdata_d = cap_q[1];
        `MBPM_OFF_PULSECTL: rdata_d = {16'h0, pulse_ctl_q};
        `MBPM_OFF_RELEASE:  rdata_d = 32'(release_q);
        default: begin
          if (paddr >= `MBPM_OFF_MATCH0 && paddr <= `MBPM_OFF_MATCH6) begin
            rdata_d = match_q[midx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= '0;
      prescale_q  <= `MBPM_RESET_WORD;
      match_ctl_q <= '0;
      cnt_ctl_q   <= '0;
      cap_ctl_q   <= '0;
      pulse_ctl_q <= '0;
      release_q   <= '0;
      count_q     <= '0;
      precount_q  <= '0;
      flags_q     <= '0;
      cap_prev_q  <= '0;
      pulse_out   <= '0;
      irq         <= 1'b0;
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      for (int i = 0; i < NMATCH; i++) begin
        match_q[i] <= `MBPM_RESET_WORD;
      end
      for (int c = 0; c < NCAP; c++) begin
        cap_q[c] <= `MBPM_RESET_WORD;
      end
    end else begin
      ctrl_q      <= ctrl_d;
      prescale_q  <= prescale_d;
      match_ctl_q <= match_ctl_d;
      cnt_ctl_q   <= cnt_ctl_d;
      cap_ctl_q   <= cap_ctl_d;
      pulse_ctl_q <= pulse_ctl_d;
      release_q   <= release_d;
      count_q     <= count_d;
      precount_q  <= precount_d;
      flags_q     <= flags_d;
      cap_prev_q  <= cap_in;
      pulse_out   <= pulse_d;
      irq         <= irq_d;
      prdata      <= rdata_d;
      pready      <= ready_d;
      pslverr     <= err_d;
      for (int i = 0; i < NMATCH; i++) begin
        match_q[i] <= match_d[i];
      end
      for (int c = 0; c < NCAP; c++) begin
        cap_q[c] <= cap_d[c];
      end
    end
  end
endmodule

// ===== verification/mbpm_load.sv
// Load on the pulse pins: high samples and period per pin
// Assumes the pins are sampled on pclk
`timescale 1ns/1ps
module mbpm_load #(
  parameter int N = 6
) (
  // Clock
  input wire logic     pclk,
  // Pins and results
  input wire logic [N:1] pins,
  output int           hi_w [N:1],
  output int           per [N:1]
);
  int         hc [N:1];
  int         pc [N:1];
  logic [N:1] prev = '0;

  // Latch counts at every rising edge of a pin
  always @(posedge pclk) begin
    prev <= pins;
    for (int i = 1; i <= N; i++) begin
      if (pins[i] && !prev[i]) begin
        hi_w[i] <= hc[i];
        per[i] <= pc[i];
        hc[i] <= 1;
        pc[i] <= 1;
      end else begin
        hc[i] <= hc[i] + int'(pins[i]);
        pc[i] <= pc[i] + 1;
      end
    end
  end
endmodule

// ===== verification/mbpm_top_properties.sv
// Port checker for the pulse modulator top
// Bound to every mbpm_top instance
`timescale 1ns/1ps
module mbpm_top_properties #(
  parameter int NOUT = 6
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Outputs
  input wire logic [NOUT:1] pulse_out,
  input wire logic        irq
);
  logic cfg_q;
  logic cfg_d;

  // Any completed write counts as configuration
  always_comb cfg_d = cfg_q | (psel & penable & pready & pwrite);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= 1'b0;
    else cfg_q <= cfg_d;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata on write");
  a_err_rdata: assert property (pslverr |-> prdata == 32'h0)
    else $error("prdata on error");
  a_unaligned_err: assert property (psel && penable && !pready && paddr[1:0] != 2'b00
    |=> pslverr) else $error("unaligned accepted");
  a_quiet_until_cfg: assert property (!cfg_q |-> pulse_out == '0 && !irq)
    else $error("output before setup");

  c_err: cover property (pslverr);
  c_read: cover property (pready && !pwrite);
  c_pulse: cover property (pulse_out != '0);
  c_irq: cover property (irq);
endmodule

bind mbpm_top mbpm_top_properties #(.NOUT(NOUT)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_out(pulse_out), .irq(irq));

// ===== verification/test_match_based_pulse_modulator.sv
// Bench for the pulse modulator: APB setup, pin widths, release, stop
// Assumes mbpm_load measures the pins
`timescale 1ns/1ps
module test_match_based_pulse_modulator;
  typedef struct {logic [31:0] mv; int w;} mbpm_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:1]  pulse_out;
  logic        sp_pready, sp_pslverr, sp_irq;
  logic [31:0] sp_prdata;
  logic [6:1]  sp_pulse;
  logic [1:0]  cap_in;
  int          hi_w [6:1];
  int          per [6:1];
  int          err_count, checks;
  mbpm_row_t   rows [6] = '{'{1, 2}, '{3, 4}, '{0, 1}, '{5, 6}, '{8, 9}, '{2, 3}};

  mbpm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .pulse_out(pulse_out), .irq(irq));
  // Second unit set up by the same writes and enabled at the same edge
  mbpm_top second_pulse_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(sp_prdata), .pready(sp_pready),
    .pslverr(sp_pslverr), .cap_in(cap_in), .pulse_out(sp_pulse), .irq(sp_irq));
  mbpm_load load_u (.pclk(pclk), .pins(pulse_out), .hi_w(hi_w), .per(per));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, pready);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(nm, x, r);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; cap_in = 0; err_count = 0; checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk("pulse_out", 0, pulse_out);
    rd("count", 8'h08, 32'h0);
    rd("ctrl", 8'h00, 32'h0);
    rd("bad", 8'h31, 32'h0);
    chk("pslverr", 1, e);
    $display("test reset done");
    wr(8'h40, 32'h9);
    for (int i = 0; i < 6; i++) wr(8'h44 + 8'(4 * i), rows[i].mv);
    wr(8'h14, 32'h2);
    wr(8'h28, 32'h7e00);
    wr(8'h00, 32'h5);
    repeat (40) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      chk("width", rows[i].w, hi_w[i + 1]);
      chk("period", 10, per[i + 1]);
    end
    chk("in step", pulse_out, sp_pulse);
    $display("test single edge done");
    wr(8'h4c, 32'h6);
    repeat (30) @(posedge pclk);
    chk("held width", 1, hi_w[3]);
    wr(8'h2c, 32'h8);
    repeat (30) @(posedge pclk);
    chk("new width", 7, hi_w[3]);
    rd("release", 8'h2c, 32'h0);
    $display("test release done");
    wr(8'h28, 32'h7e04);
    repeat (30) @(posedge pclk);
    chk("positive", 2, hi_w[2]);
    wr(8'h44, 32'h8);
    wr(8'h2c, 32'h2);
    repeat (40) @(posedge pclk);
    chk("negative", 5, hi_w[2]);
    chk("single", 9, hi_w[1]);
    $display("test double edge done");
    wr(8'h0c, 32'h1);
    repeat (60) @(posedge pclk);
    chk("scaled period", 20, per[4]);
    chk("scaled width", 12, hi_w[4]);
    $display("test prescale done");
    wr(8'h00, 32'h1);
    repeat (2) @(negedge pclk);
    chk("timer pins", 0, pulse_out);
    wr(8'h14, 32'ha02);
    repeat (40) @(posedge pclk);
    rd("stopped", 8'h00, 32'h0);
    @(negedge pclk);
    chk("irq", 1, irq);
    wr(8'h04, 32'h37f);
    repeat (2) @(negedge pclk);
    chk("irq clear", 0, irq);
    rd("stop count", 8'h08, 32'h7);
    $display("test stop done");
    wr(8'h1c, 32'h5);
    @(posedge pclk);
    cap_in <= 2'b01;
    repeat (3) @(posedge pclk);
    cap_in <= 2'b00;
    rd("capture", 8'h20, 32'h7);
    rd("cap flag", 8'h04, 32'h100);
    chk("cap irq", 1, irq);
    wr(8'h0c, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h1);
    repeat (2) begin
      repeat (3) @(posedge pclk);
      cap_in <= 2'b01;
      repeat (3) @(posedge pclk);
      cap_in <= 2'b00;
    end
    rd("edge count", 8'h08, 32'h9);
    chk("in step irq", irq, sp_irq);
    chk("in step pins", pulse_out, sp_pulse);
    $display("test capture done");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
endmodule
